// ===== hw/rsm_monitor.sv
// Receiver status and error monitor with AHB-Lite registers
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - No error: fault low, green blink once/second
// - Red lamp shown when not operating correctly
// - Non-fatal conditions set status bits, keep tracking
// - Status bits other than bit 0 follow live conditions, not latched
// - Fatal condition sets its error word bit
// - Any latched error sets status bit 0
// - Error state: fault high, red/yellow code flash
// - Entering error state issues cause event report
// - Error disables tracking, commands/reports continue
// - Error latched until host reset
// - Set/clear masks trigger reports on edges
// - Promote mask turns status conditions fatal
// - Error idles channels, antenna off, RF off
// - Aux promote masks set assigned status bit
// - Status word exported for message headers
// - Reports enabled at reset, host can disable
// - Error word is 32 bits, one per cause
module rsm_monitor
  import rsm_pkg::*;
#(
  parameter int AUX_NUM = 4,
  parameter int BLINK_CNT = BLINK_CYCLES,
  parameter int FLASH_CNT = FLASH_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire rsm_ahb_in_type ahb_in,
  output rsm_ahb_out_type ahb_out,
  // Condition sources, same clock domain
  input wire logic [31:0] cond_status,
  input wire logic [31:0] cond_fatal,
  input wire logic [AUX_NUM*32-1:0] cond_aux,
  // Host reset request, synchronous
  input wire logic host_reset,
  // Device outputs
  output logic fault_out,
  output rsm_lamp_type lamp,
  output logic track_en,
  output logic antenna_pwr_en,
  output logic rf_en,
  output logic [31:0] header_status,
  output rsm_report_type status_event_report,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] error;
    logic err_state;
    logic [31:0] prio;
    logic [31:0] rise;
    logic [31:0] fall;
    logic [AUX_NUM*32-1:0] aux_prio;
    logic report_en;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    rsm_report_type rpt;
    logic [31:0] rpt_cause;
    logic [31:0] rpt_status;
    logic dp_act;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic [31:0] tick;
    logic [5:0] slot;
    logic [5:0] code;
  } rsm_state_type;

  rsm_state_type st_ff;
  rsm_state_type nxt_st;

  logic [31:0] aux_hit;
  logic [31:0] live_status;
  logic [31:0] promoted;
  logic [31:0] new_error;
  logic [31:0] rise_evt;
  logic [31:0] fall_evt;
  logic [5:0] low_idx;
  logic addr_take;
  logic soft_rst;

  ////////////////////////////////////////////////////////////////////////////
  // Aux arrays: any promoted aux condition sets its status bit
  genvar k;
  generate
    for (k = 0; k < 32; k++) begin : g_aux
      if (k >= AUX_BIT_BASE && k < AUX_BIT_BASE + AUX_NUM) begin : g_on
        assign aux_hit[k] = |(cond_aux[(k-AUX_BIT_BASE)*32 +: 32] &
                              st_ff.aux_prio[(k-AUX_BIT_BASE)*32 +: 32]);
      end else begin : g_off
        assign aux_hit[k] = 1'b0;
      end
    end
  endgenerate

  // Lowest set error bit for the lamp code
  always_comb begin
    low_idx = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (st_ff.error[i]) begin
        low_idx = 6'(i);
      end
    end
  end

  // Live status and error causes
  always_comb begin
    live_status = cond_status | aux_hit;
    live_status[STATUS_ERR_BIT] = st_ff.err_state | (|st_ff.error);
    promoted = cond_status & st_ff.prio;
    new_error = cond_fatal | promoted;
    rise_evt = live_status & ~st_ff.status & st_ff.rise;
    fall_evt = ~live_status & st_ff.status & st_ff.fall;
  end

  assign addr_take = ahb_in.hsel & ahb_in.hready & ahb_in.htrans[1];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st = st_ff;
    soft_rst = 1'b0;

    // Status follows live conditions
    nxt_st.status = live_status;
    // Error word latches, cleared only by reset
    nxt_st.error = st_ff.error | new_error;
    nxt_st.err_state = st_ff.err_state | (|new_error);
    nxt_st.status[STATUS_ERR_BIT] = nxt_st.err_state;

    // Event reports
    nxt_st.rpt.valid = 1'b0;
    if (st_ff.report_en) begin
      if (|new_error & ~st_ff.err_state) begin
        nxt_st.rpt.valid = 1'b1;
        nxt_st.rpt.cause = new_error;
      end else if (|(rise_evt | fall_evt)) begin
        nxt_st.rpt.valid = 1'b1;
        nxt_st.rpt.cause = rise_evt | fall_evt;
      end
      nxt_st.rpt.status = nxt_st.status;
      nxt_st.rpt.error = nxt_st.error;
    end
    if (nxt_st.rpt.valid) begin
      nxt_st.rpt_cause = nxt_st.rpt.cause;
      nxt_st.rpt_status = nxt_st.rpt.status;
    end

    // Sticky interrupt events
    if (|new_error & ~st_ff.err_state) begin
      nxt_st.irq_stat[IRQ_ERR_BIT] = 1'b1;
    end
    if (nxt_st.rpt.valid) begin
      nxt_st.irq_stat[IRQ_EVT_BIT] = 1'b1;
    end
    if (nxt_st.status != st_ff.status) begin
      nxt_st.irq_stat[IRQ_STAT_BIT] = 1'b1;
    end

    // Lamp sequencer
    if (st_ff.tick == 32'(st_ff.err_state ? FLASH_CNT - 1 : BLINK_CNT / 2 - 1)) begin
      nxt_st.tick = 32'h0000_0000;
      nxt_st.slot = st_ff.slot + 6'h01;
      if (st_ff.err_state && st_ff.slot >= st_ff.code + CODE_GAP_SLOTS) begin
        nxt_st.slot = 6'h00;
        nxt_st.code = low_idx + 6'h01;
      end
    end else begin
      nxt_st.tick = st_ff.tick + 32'h0000_0001;
    end
    if (|new_error & ~st_ff.err_state) begin
      nxt_st.tick = 32'h0000_0000;
      nxt_st.slot = 6'h00;
      nxt_st.code = 6'h3f;
    end

    // AHB data phase
    nxt_st.dp_act = addr_take;
    nxt_st.dp_wr = addr_take & ahb_in.hwrite;
    nxt_st.dp_addr = ahb_in.haddr[7:0];
    if (st_ff.dp_wr) begin
      unique case (st_ff.dp_addr)
        OFS_PRIO: nxt_st.prio = ahb_in.hwdata;
        OFS_RISE: nxt_st.rise = ahb_in.hwdata;
        OFS_FALL: nxt_st.fall = ahb_in.hwdata;
        OFS_CTRL: begin
          nxt_st.report_en = ahb_in.hwdata[CTRL_REPORT_EN_BIT];
          soft_rst = ahb_in.hwdata[CTRL_SOFT_RST_BIT];
        end
        OFS_IRQ_CLR: nxt_st.irq_stat = st_ff.irq_stat & ~ahb_in.hwdata[2:0];
        OFS_IRQ_EN: nxt_st.irq_en = ahb_in.hwdata[2:0];
        default: begin
          for (int a = 0; a < AUX_NUM; a++) begin
            if (st_ff.dp_addr == OFS_AUX_PRIO0 + 8'(4 * a)) begin
              nxt_st.aux_prio[a*32 +: 32] = ahb_in.hwdata;
            end
          end
        end
      endcase
      // Set wins over clear
      if (st_ff.dp_addr == OFS_IRQ_CLR) begin
        nxt_st.irq_stat[IRQ_ERR_BIT] = nxt_st.irq_stat[IRQ_ERR_BIT] | (|new_error & ~st_ff.err_state);
        nxt_st.irq_stat[IRQ_EVT_BIT] = nxt_st.irq_stat[IRQ_EVT_BIT] | nxt_st.rpt.valid;
        nxt_st.irq_stat[IRQ_STAT_BIT] = nxt_st.irq_stat[IRQ_STAT_BIT] | (nxt_st.status != st_ff.status);
      end
    end

    // Read data captured in address phase
    nxt_st.rdata = 32'h0000_0000;
    if (addr_take & ~ahb_in.hwrite) begin
      unique case (ahb_in.haddr[7:0])
        OFS_STATUS: nxt_st.rdata = st_ff.status;
        OFS_ERROR: nxt_st.rdata = st_ff.error;
        OFS_PRIO: nxt_st.rdata = st_ff.prio;
        OFS_RISE: nxt_st.rdata = st_ff.rise;
        OFS_FALL: nxt_st.rdata = st_ff.fall;
        OFS_CTRL: nxt_st.rdata = {31'h0, st_ff.report_en};
        OFS_IRQ_STAT: nxt_st.rdata = {29'h0, st_ff.irq_stat};
        OFS_IRQ_EN: nxt_st.rdata = {29'h0, st_ff.irq_en};
        OFS_EVT_DATA: nxt_st.rdata = st_ff.rpt_status;
        OFS_EVT_CAUSE: nxt_st.rdata = st_ff.rpt_cause;
        default: begin
          for (int a = 0; a < AUX_NUM; a++) begin
            if (ahb_in.haddr[7:0] == OFS_AUX_PRIO0 + 8'(4 * a)) begin
              nxt_st.rdata = st_ff.aux_prio[a*32 +: 32];
            end
          end
        end
      endcase
    end

    // Synchronous host reset clears latch, status and lamp
    if (host_reset | soft_rst) begin
      nxt_st.status = 32'h0000_0000;
      nxt_st.error = 32'h0000_0000;
      nxt_st.err_state = 1'b0;
      nxt_st.tick = 32'h0000_0000;
      nxt_st.slot = 6'h00;
      nxt_st.code = 6'h00;
      nxt_st.rpt.valid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.prio <= RST_PRIO;
      st_ff.rise <= RST_RISE;
      st_ff.fall <= RST_FALL;
      st_ff.aux_prio <= {AUX_NUM{RST_AUX_PRIO}};
      st_ff.report_en <= RST_REPORT_EN;
      st_ff.irq_en <= RST_IRQ_EN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    if (!st_ff.err_state) begin
      lamp = st_ff.slot[0] ? LAMP_OFF : LAMP_GREEN;
    end else if (st_ff.slot == 6'h00) begin
      lamp = LAMP_RED;
    end else if (st_ff.slot <= st_ff.code) begin
      lamp = st_ff.slot[0] ? LAMP_YELLOW : LAMP_RED;
    end else begin
      lamp = LAMP_OFF;
    end
  end

  assign fault_out = st_ff.err_state;
  assign track_en = ~st_ff.err_state;
  assign antenna_pwr_en = ~st_ff.err_state;
  assign rf_en = ~st_ff.err_state;
  assign header_status = st_ff.status;
  assign status_event_report = st_ff.rpt;
  assign irq = |(st_ff.irq_stat & st_ff.irq_en);
  assign ahb_out.hreadyout = 1'b1;
  assign ahb_out.hresp = 1'b0;
  assign ahb_out.hrdata = st_ff.rdata;

endmodule

// ===== hw/rsm_pkg.sv
// Package for the receiver status and error monitor
package rsm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00; // Live status word, read only
  localparam logic [7:0] OFS_ERROR = 8'h04; // Latched error word, read only
  localparam logic [7:0] OFS_PRIO = 8'h08; // Promote mask
  localparam logic [7:0] OFS_RISE = 8'h0c; // Rise event mask
  localparam logic [7:0] OFS_FALL = 8'h10; // Fall event mask
  localparam logic [7:0] OFS_AUX_PRIO0 = 8'h14; // Aux promote masks at 0x14 + 4*k
  localparam logic [7:0] OFS_CTRL = 8'h24; // Bit 0 report enable, bit 1 soft reset
  localparam logic [7:0] OFS_IRQ_STAT = 8'h28; // Sticky interrupt status, read only
  localparam logic [7:0] OFS_IRQ_CLR = 8'h2c; // Write one to clear
  localparam logic [7:0] OFS_IRQ_EN = 8'h30; // Interrupt enable
  localparam logic [7:0] OFS_EVT_DATA = 8'h34; // Status word of last event report
  localparam logic [7:0] OFS_EVT_CAUSE = 8'h38; // Last event cause word

  // Reset values
  localparam logic [31:0] RST_PRIO = 32'h0000_0000;
  localparam logic [31:0] RST_RISE = 32'h0000_0000;
  localparam logic [31:0] RST_FALL = 32'h0000_0000;
  localparam logic [31:0] RST_AUX_PRIO = 32'h0000_0000;
  localparam logic RST_REPORT_EN = 1'b1;
  localparam logic [2:0] RST_IRQ_EN = 3'h0;

  // Field positions
  localparam int STATUS_ERR_BIT = 0; // Summary error flag
  localparam int AUX_BIT_BASE = 28; // Aux array k sets status bit 28+k
  localparam int CTRL_REPORT_EN_BIT = 0;
  localparam int CTRL_SOFT_RST_BIT = 1;
  localparam int IRQ_ERR_BIT = 0; // Error state entered
  localparam int IRQ_EVT_BIT = 1; // Event report issued
  localparam int IRQ_STAT_BIT = 2; // Status word changed

  // Lamp timing
  localparam int CLK_HZ = 100_000_000;
  localparam int BLINK_PERIOD_MS = 1000; // About once per second
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_PERIOD_MS;
  localparam int FLASH_MS = 250; // Red/yellow flash slot
  localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
  localparam logic [5:0] CODE_GAP_SLOTS = 6'h04; // Dark slots between code repeats

  // Lamp colours
  typedef enum logic [1:0] {LAMP_OFF, LAMP_GREEN, LAMP_RED, LAMP_YELLOW} rsm_lamp_type;

  // Event report record
  typedef struct packed {
    logic valid;
    logic [31:0] status;
    logic [31:0] error;
    logic [31:0] cause;
  } rsm_report_type;

  // AHB-Lite slave side
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } rsm_ahb_in_type;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } rsm_ahb_out_type;

endpackage

// ===== verification/rsm_host_model.sv
// Host model that counts event reports and pulses the host reset
`timescale 1ns/100ps
module rsm_host_model
  import rsm_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Device side
  input wire logic fault_out,
  input wire rsm_report_type status_event_report,
  output logic host_reset,
  // Bench side
  input wire logic reset_req,
  output int rpt_cnt,
  output logic [31:0] last_cause
);
  // One-cycle reset pulse, only while a fault is latched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_reset <= 1'b0;
      rpt_cnt <= 0;
      last_cause <= 32'h0;
    end else begin
      host_reset <= reset_req && fault_out && !host_reset;
      if (status_event_report.valid) begin
        rpt_cnt <= rpt_cnt + 1;
        last_cause <= status_event_report.cause;
      end
    end
  end
endmodule

// ===== verification/rsm_monitor_assertions.sv
// Port checker for the status and error monitor
`timescale 1ns/100ps
module rsm_monitor_assertions
  import rsm_pkg::*;
#(parameter int AUX_NUM = 4) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire rsm_ahb_in_type ahb_in,
  input wire rsm_ahb_out_type ahb_out,
  // Conditions
  input wire logic [31:0] cond_status,
  input wire logic [31:0] cond_fatal,
  input wire logic [AUX_NUM*32-1:0] cond_aux,
  input wire logic host_reset,
  // Device outputs
  input wire logic fault_out,
  input wire rsm_lamp_type lamp,
  input wire logic track_en,
  input wire logic antenna_pwr_en,
  input wire logic rf_en,
  input wire logic [31:0] header_status,
  input wire rsm_report_type status_event_report,
  input wire logic irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Control write in its data phase, to spot a soft reset request
  logic ctrl_wr_dp;
  logic soft_req;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_wr_dp <= 1'b0;
    end else begin
      ctrl_wr_dp <= ahb_in.hsel & ahb_in.hready & ahb_in.htrans[1] & ahb_in.hwrite & (ahb_in.haddr[7:0] == OFS_CTRL);
    end
  end
  assign soft_req = ctrl_wr_dp & ahb_in.hwdata[CTRL_SOFT_RST_BIT];
  // Error entry steps
  sequence s_fatal; |cond_fatal && !host_reset; endsequence
  sequence s_enter; !fault_out ##1 fault_out; endsequence
  chk_fatal_sets_fault: assert property (s_fatal |=> fault_out && header_status[0])
    else $error("fault or summary bit missing");
  chk_fault_stays_latched: assert property ($fell(fault_out) |-> $past(host_reset) || $past(soft_req))
    else $error("fault dropped without reset");
  chk_err_outputs_off: assert property (fault_out |-> !track_en && !antenna_pwr_en && !rf_en)
    else $error("tracking still on in error");
  chk_ok_outputs_on: assert property (!fault_out |-> track_en && antenna_pwr_en && rf_en)
    else $error("tracking off without error");
  chk_ok_lamp_green: assert property (!fault_out |-> lamp inside {LAMP_GREEN, LAMP_OFF})
    else $error("lamp not green in normal state");
  chk_err_lamp_code: assert property (fault_out |-> lamp != LAMP_GREEN)
    else $error("lamp green in error state");
  chk_status_follows_live: assert property (!host_reset |=> header_status[27:1] == $past(cond_status[27:1]))
    else $error("status word not following conditions");
  chk_entry_report_sent: assert property (s_enter |-> status_event_report.valid && |status_event_report.cause)
    else $error("no report on error entry");
endmodule
bind rsm_monitor rsm_monitor_assertions #(.AUX_NUM(AUX_NUM)) u_rsm_monitor_assertions (
  .hclk(hclk), .hresetn(hresetn), .ahb_in(ahb_in), .ahb_out(ahb_out), .cond_status(cond_status),
  .cond_fatal(cond_fatal), .cond_aux(cond_aux), .host_reset(host_reset), .fault_out(fault_out), .lamp(lamp),
  .track_en(track_en), .antenna_pwr_en(antenna_pwr_en), .rf_en(rf_en), .header_status(header_status),
  .status_event_report(status_event_report), .irq(irq));

// ===== verification/rsm_monitor_test.sv
// Testbench for the status and error monitor
`timescale 1ns/100ps
module rsm_monitor_test
  import rsm_pkg::*;
;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} rsm_row_type;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  rsm_ahb_in_type bi = '0;
  rsm_ahb_in_type ahb_in;
  rsm_ahb_out_type ahb_out;
  logic [31:0] cond_status = '0;
  logic [31:0] cond_fatal = '0;
  logic [127:0] cond_aux = '0;
  logic reset_req = 1'b0;
  logic host_reset, fault_out, track_en, antenna_pwr_en, rf_en, irq;
  rsm_lamp_type lamp;
  logic [31:0] header_status, last_cause, rd;
  rsm_report_type status_event_report;
  logic [3:0] seen;
  int rpt_cnt, base;
  int error_cnt = 0;
  int checks_done = 0;
  // Register rows: write flag, offset, data, expected read
  rsm_row_type rows [8] = '{'{1'b0, OFS_STATUS, 32'h0, 32'h0}, '{1'b0, OFS_ERROR, 32'h0, 32'h0},
    '{1'b0, OFS_PRIO, 32'h0, RST_PRIO}, '{1'b1, OFS_STATUS, 32'hffff_ffff, 32'h0},
    '{1'b1, OFS_RISE, 32'h10, 32'h10}, '{1'b1, OFS_FALL, 32'h10, 32'h10},
    '{1'b1, OFS_AUX_PRIO0, 32'h1, 32'h1}, '{1'b1, 8'h40, 32'hffff_ffff, 32'h0}};
  always #5 hclk = ~hclk;
  // Bus ready loops back from the slave
  always_comb begin
    ahb_in = bi;
    ahb_in.hready = ahb_out.hreadyout;
  end
  rsm_monitor #(.AUX_NUM(4), .BLINK_CNT(20), .FLASH_CNT(5)) u_rsm_monitor (
    .hclk(hclk), .hresetn(hresetn), .ahb_in(ahb_in), .ahb_out(ahb_out), .cond_status(cond_status),
    .cond_fatal(cond_fatal), .cond_aux(cond_aux), .host_reset(host_reset), .fault_out(fault_out),
    .lamp(lamp), .track_en(track_en), .antenna_pwr_en(antenna_pwr_en), .rf_en(rf_en),
    .header_status(header_status), .status_event_report(status_event_report), .irq(irq));
  rsm_host_model u_rsm_host_model (.hclk(hclk), .hresetn(hresetn), .fault_out(fault_out),
    .status_event_report(status_event_report), .host_reset(host_reset), .reset_req(reset_req),
    .rpt_cnt(rpt_cnt), .last_cause(last_cause));
  // Compare and count
  task automatic check(input string nm, input logic [31:0] sv, input logic [31:0] ev);
    checks_done++;
    if (sv !== ev) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, ev, sv);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Bounded wait for hready
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (ahb_out.hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  // Single word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    bi.hsel <= 1'b1;
    bi.haddr <= {24'h0, a};
    bi.htrans <= 2'h2;
    bi.hwrite <= wr;
    bi.hsize <= 3'h2;
    wait_ready();
    bi.hsel <= 1'b0;
    bi.htrans <= 2'h0;
    bi.hwdata <= d;
    wait_ready();
    r = ahb_out.hrdata;
  endtask
  // Record lamp colours seen
  task automatic lamp_watch(input int n);
    seen = '0;
    repeat (n) begin
      @(posedge hclk);
      seen[lamp] = 1'b1;
    end
  endtask
  // Main sequence
  initial begin
    tick(8);
    hresetn <= 1'b1;
    tick(1);
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d, rd);
      bus(1'b0, rows[i].a, 32'h0, rd);
      check($sformatf("reg %h", rows[i].a), rd, rows[i].e);
      check("hresp", ahb_out.hresp, 1'b0);
    end
    lamp_watch(60);
    check("lamp normal", seen, 4'b0011);
    base = rpt_cnt;
    cond_status <= 32'h10;
    tick(2);
    check("status set", {fault_out, header_status[30:0]}, 32'h10);
    cond_status <= 32'h0;
    tick(2);
    check("status clear", header_status, 32'h0);
    tick(3);
    check("edge reports", rpt_cnt - base, 32'h2);
    bus(1'b1, OFS_CTRL, 32'h0, rd);
    base = rpt_cnt;
    cond_status <= 32'h10;
    tick(3);
    cond_status <= 32'h0;
    tick(3);
    check("muted reports", rpt_cnt - base, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h1, rd);
    cond_aux <= 128'h1;
    tick(2);
    check("aux bit", header_status, 32'h1000_0000);
    cond_aux <= '0;
    bus(1'b1, OFS_PRIO, 32'h20, rd);
    cond_status <= 32'h20;
    tick(2);
    check("promoted", {track_en, rf_en, antenna_pwr_en, fault_out}, 4'b0001);
    cond_status <= 32'h0;
    tick(4);
    check("latched", fault_out, 1'b1);
    reset_req <= 1'b1;
    tick(3);
    reset_req <= 1'b0;
    check("host reset", {track_en, fault_out, header_status[0]}, 3'b100);
    bus(1'b1, OFS_IRQ_CLR, 32'h7, rd);
    bus(1'b1, OFS_IRQ_EN, 32'h1, rd);
    cond_fatal <= 32'h8;
    tick(3);
    check("cause", last_cause, 32'h8);
    check("report error", status_event_report.error, 32'h8);
    check("irq", irq, 1'b1);
    bus(1'b0, OFS_ERROR, 32'h0, rd);
    check("error word", rd, 32'h8);
    bus(1'b0, OFS_STATUS, 32'h0, rd);
    check("summary", rd[0], 1'b1);
    bus(1'b0, OFS_EVT_CAUSE, 32'h0, rd);
    check("evt cause", rd, 32'h8);
    bus(1'b0, OFS_EVT_DATA, 32'h0, rd);
    check("evt status", rd, 32'h1);
    bus(1'b1, OFS_IRQ_EN, 32'h0, rd);
    tick(1);
    check("irq masked", irq, 1'b0);
    bus(1'b1, OFS_IRQ_EN, 32'h1, rd);
    bus(1'b1, OFS_IRQ_CLR, 32'h1, rd);
    tick(1);
    check("irq cleared", irq, 1'b0);
    lamp_watch(500);
    check("lamp error", seen, 4'b1101);
    cond_fatal <= 32'h0;
    bus(1'b1, OFS_CTRL, 32'h3, rd);
    tick(1);
    check("soft reset", {fault_out, track_en}, 2'b01);
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    tick(2);
    check("hw reset", {track_en, fault_out, header_status[0]}, 3'b100);
    bus(1'b0, OFS_PRIO, 32'h0, rd);
    check("prio reset", rd, RST_PRIO);
    give_verdict();
  end
endmodule
